/* File: common/tiod_defines.vh */
// Purpose: constants for the timer and i/o transfer decoder
// Assumes: 10-bit instruction words, 4-bit data path
// Notes: offsets are byte addresses on the register bus
`ifndef TIOD_DEFINES_VH
`define TIOD_DEFINES_VH

// instruction codes
`define TIOD_OP_READ_T1 10'h270
`define TIOD_OP_LOAD_T1 10'h230
`define TIOD_OP_LOAD_DISP 10'h20d
`define TIOD_OP_READ_PORT0 10'h260
`define TIOD_OP_WRITE_PORT0 10'h220
`define TIOD_OP_READ_PORT1 10'h261
`define TIOD_OP_WRITE_PORT1 10'h221
`define TIOD_OP_READ_PORT2 10'h262
`define TIOD_OP_SET_ALL_D 10'h011
`define TIOD_OP_CLR_D 10'h014
`define TIOD_OP_SET_D 10'h015
`define TIOD_OP_WRITE_PU 10'h22d
`define TIOD_OP_READ_PU 10'h257

// widths and index limit
`define TIOD_D_BITS 10
`define TIOD_Y_MAX 4'h9

// register bus offsets
`define TIOD_REG_CTRL 4'h0
`define TIOD_REG_STATUS 4'h4
`define TIOD_REG_COUNT 4'h8

// field positions and reset values
`define TIOD_CTRL_ENABLE 0
`define TIOD_CTRL_RESET 1'h1
`define TIOD_PU_RESET 4'h0
`define TIOD_D_RESET 10'h000
`define TIOD_PORT_RESET 4'hf

// bus responses
`define TIOD_RESP_OKAY 2'h0
`define TIOD_RESP_SLVERR 2'h2

`endif

/* File: src/tiod_pin_sync.v */
// Purpose: three-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous to clk
// Notes: the output follows once the second and third stages agree
module tiod_pin_sync #(
   parameter WIDTH = 4
) (
   // clock and reset
   input wire clk,
   input wire rst_b,
   input wire ce,
   // pins and synchronised level
   input wire [WIDTH-1:0] pin,
   output reg [WIDTH-1:0] level
);

   reg [WIDTH-1:0] stage1;
   reg [WIDTH-1:0] stage2;
   reg [WIDTH-1:0] stage3;
   wire [WIDTH-1:0] agree;
   genvar i;

   ////////////////////////////////////////////////////////////////////////
   // capture chain, first stage feeds only the second
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stage1 <= {WIDTH{1'b1}};
         stage2 <= {WIDTH{1'b1}};
         stage3 <= {WIDTH{1'b1}};
      end else if (ce) begin
         stage1 <= pin;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per-bit agreement of the last two stages
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         assign agree[i] = (stage2[i] == stage3[i]);
      end
   endgenerate

   // a bit follows only once the last two stages agree; one process drives level
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         level <= {WIDTH{1'b1}};
      end else if (ce) begin
         level <= (level & ~agree) | (stage3 & agree);
      end
   end

endmodule // tiod_pin_sync

/* File: src/tiod_decoder.v */
// Purpose: decodes and executes the timer and i/o transfer instructions
// Assumes: the fetch sequencer presents one word per cycle with instr_valid
// Notes: results appear one clock after the word is taken
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`include "tiod_defines.vh"

module tiod_decoder (
   // clock, reset, enable
   input wire clk,
   input wire rst_b,
   input wire ce,
   // instruction from fetch sequencer
   input wire [9:0] instr,
   input wire instr_valid,
   input wire [3:0] acc_in,
   input wire [3:0] upper_in,
   input wire [3:0] index_y,
   input wire timer_run,
   input wire [7:0] first_timer_count_in,
   // core register write-back
   output reg [3:0] acc_out,
   output reg acc_we,
   output reg [3:0] upper_out,
   output reg upper_we,
   output reg instr_done,
   // first timer
   output reg [7:0] first_timer_load_data,
   output reg first_timer_load,
   output reg [7:0] first_timer_reload,
   // display timer
   output reg [3:0] display_timer_count,
   output reg display_timer_load,
   output reg [3:0] display_timer_reload_latch,
   // ports
   input wire [3:0] first_bidir_port_pin,
   input wire [3:0] second_bidir_port_pin,
   input wire [3:0] input_only_port_pin,
   output reg [3:0] first_bidir_port_out,
   output reg [3:0] second_bidir_port_out,
   output reg [`TIOD_D_BITS-1:0] output_port,
   output reg [3:0] pullup_enable_register,
   // axi4-lite slave
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);

   wire [3:0] port0_level;
   wire [3:0] port1_level;
   wire [3:0] port2_level;
   reg ctrl_enable;
   reg [9:0] last_opcode;
   reg [15:0] exec_count;
   reg aw_held;
   reg w_held;
   reg [3:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   wire take;
   reg [`TIOD_D_BITS-1:0] next_output_port;

   // true when a 4-bit byte address names a mapped register
   function is_mapped;
      input [3:0] addr;
      begin
         is_mapped = (addr == `TIOD_REG_CTRL) || (addr == `TIOD_REG_STATUS) ||
                     (addr == `TIOD_REG_COUNT);
      end
   endfunction

   // one-hot mask for the indexed output bit, empty when index is out of range
   function [`TIOD_D_BITS-1:0] bit_mask;
      input [3:0] y;
      begin
         if (y <= `TIOD_Y_MAX) begin
            bit_mask = {{(`TIOD_D_BITS-1){1'b0}}, 1'b1} << y;
         end else begin
            bit_mask = {`TIOD_D_BITS{1'b0}};
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   tiod_pin_sync #(.WIDTH(4)) u_sync_port0 (
      .clk(clk),
      .rst_b(rst_b),
      .ce(ce),
      .pin(first_bidir_port_pin),
      .level(port0_level)
   );

   tiod_pin_sync #(.WIDTH(4)) u_sync_port1 (
      .clk(clk),
      .rst_b(rst_b),
      .ce(ce),
      .pin(second_bidir_port_pin),
      .level(port1_level)
   );

   tiod_pin_sync #(.WIDTH(4)) u_sync_port2 (
      .clk(clk),
      .rst_b(rst_b),
      .ce(ce),
      .pin(input_only_port_pin),
      .level(port2_level)
   );

   // an instruction is taken only while software has the decoder enabled
   assign take = ce && instr_valid && ctrl_enable;

   ////////////////////////////////////////////////////////////////////////
   // next value of the output-only port
   always @* begin
      next_output_port = output_port;
      case (instr)
         `TIOD_OP_SET_ALL_D: begin
            next_output_port = {`TIOD_D_BITS{1'b1}};
         end
         `TIOD_OP_CLR_D: begin
            next_output_port = output_port & ~bit_mask(index_y);
         end
         `TIOD_OP_SET_D: begin
            next_output_port = output_port | bit_mask(index_y);
         end
         default: begin
            next_output_port = output_port;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // execution: every word finishes one clock after it is taken
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         acc_out <= 4'h0;
         acc_we <= 1'b0;
         upper_out <= 4'h0;
         upper_we <= 1'b0;
         instr_done <= 1'b0;
         first_timer_load_data <= 8'h00;
         first_timer_load <= 1'b0;
         first_timer_reload <= 8'h00;
         display_timer_count <= 4'h0;
         display_timer_load <= 1'b0;
         display_timer_reload_latch <= 4'h0;
         first_bidir_port_out <= `TIOD_PORT_RESET;
         second_bidir_port_out <= `TIOD_PORT_RESET;
         output_port <= `TIOD_D_RESET;
         pullup_enable_register <= `TIOD_PU_RESET;
         last_opcode <= 10'h000;
         exec_count <= 16'h0000;
      end else if (ce) begin
         acc_we <= 1'b0;
         upper_we <= 1'b0;
         first_timer_load <= 1'b0;
         display_timer_load <= 1'b0;
         instr_done <= take;
         if (take) begin
            last_opcode <= instr;
            exec_count <= exec_count + 16'h0001;
            output_port <= next_output_port;
            case (instr)
               `TIOD_OP_READ_T1: begin
                  upper_out <= first_timer_count_in[7:4];
                  upper_we <= 1'b1;
                  acc_out <= first_timer_count_in[3:0];
                  acc_we <= 1'b1;
               end
               `TIOD_OP_LOAD_T1: begin
                  first_timer_reload <= {upper_in, acc_in};
                  if (!timer_run) begin
                     first_timer_load_data <= {upper_in, acc_in};
                     first_timer_load <= 1'b1;
                  end
               end
               `TIOD_OP_LOAD_DISP: begin
                  display_timer_count <= acc_in;
                  display_timer_reload_latch <= acc_in;
                  display_timer_load <= 1'b1;
               end
               `TIOD_OP_READ_PORT0: begin
                  acc_out <= port0_level;
                  acc_we <= 1'b1;
               end
               `TIOD_OP_WRITE_PORT0: begin
                  first_bidir_port_out <= acc_in;
               end
               `TIOD_OP_READ_PORT1: begin
                  acc_out <= port1_level;
                  acc_we <= 1'b1;
               end
               `TIOD_OP_WRITE_PORT1: begin
                  second_bidir_port_out <= acc_in;
               end
               `TIOD_OP_READ_PORT2: begin
                  acc_out <= port2_level;
                  acc_we <= 1'b1;
               end
               `TIOD_OP_WRITE_PU: begin
                  pullup_enable_register <= acc_in;
               end
               `TIOD_OP_READ_PU: begin
                  acc_out <= pullup_enable_register;
                  acc_we <= 1'b1;
               end
               default: begin
                  acc_we <= 1'b0;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bus write: address and data taken in either order, then one response
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TIOD_RESP_OKAY;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 4'h0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         ctrl_enable <= `TIOD_CTRL_RESET;
      end else if (ce) begin
         s_axi_awready <= !aw_held && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= !w_held && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (aw_held && w_held && !s_axi_bvalid) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_addr == `TIOD_REG_CTRL) begin
               s_axi_bresp <= `TIOD_RESP_OKAY;
               if (w_strb[0]) begin
                  ctrl_enable <= w_data[`TIOD_CTRL_ENABLE];
               end
            end else if (is_mapped(aw_addr)) begin
               s_axi_bresp <= `TIOD_RESP_OKAY; // read-only, write ignored
            end else begin
               s_axi_bresp <= `TIOD_RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bus read: data one cycle after the address is taken
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `TIOD_RESP_OKAY;
      end else if (ce) begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= is_mapped(s_axi_araddr) ? `TIOD_RESP_OKAY : `TIOD_RESP_SLVERR;
            case (s_axi_araddr)
               `TIOD_REG_CTRL: begin
                  s_axi_rdata <= {31'h0, ctrl_enable};
               end
               `TIOD_REG_STATUS: begin
                  s_axi_rdata <= {8'h00, pullup_enable_register, last_opcode, output_port};
               end
               `TIOD_REG_COUNT: begin
                  s_axi_rdata <= {16'h0000, exec_count};
               end
               default: begin
                  s_axi_rdata <= 32'h00000000;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule // tiod_decoder

/* File: verification/tiod_decoder_asserts.sv */
// Purpose: port checks for the transfer decoder
// Assumes: ce high, decode enable left set
// Notes: bound to every decoder instance
`include "tiod_defines.vh"
module tiod_decoder_asserts (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // instruction side
   input wire logic [9:0] instr,
   input wire logic instr_valid,
   input wire logic timer_run,
   input wire logic acc_we,
   input wire logic upper_we,
   input wire logic instr_done,
   input wire logic first_timer_load,
   input wire logic display_timer_load,
   input wire logic [3:0] acc_in,
   input wire logic [3:0] upper_in,
   input wire logic [3:0] index_y,
   input wire logic [3:0] acc_out,
   input wire logic [3:0] upper_out,
   input wire logic [7:0] first_timer_count_in,
   input wire logic [7:0] first_timer_load_data,
   input wire logic [7:0] first_timer_reload,
   // latches and ports
   input wire logic [3:0] display_timer_count,
   input wire logic [3:0] display_timer_reload_latch,
   input wire logic [3:0] first_bidir_port_out,
   input wire logic [3:0] second_bidir_port_out,
   input wire logic [3:0] pullup_enable_register,
   input wire logic [9:0] output_port
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   chk_timer_read: assert property (
      instr_valid && instr == `TIOD_OP_READ_T1 |=> acc_we && upper_we &&
      {upper_out, acc_out} == $past(first_timer_count_in)) else $error("timer read");
   chk_load_stopped: assert property (
      instr_valid && instr == `TIOD_OP_LOAD_T1 && !timer_run |=> first_timer_load &&
      first_timer_load_data == {$past(upper_in), $past(acc_in)} &&
      first_timer_reload == first_timer_load_data) else $error("stopped load");
   chk_load_running: assert property (
      instr_valid && instr == `TIOD_OP_LOAD_T1 && timer_run |=> !first_timer_load &&
      $stable(first_timer_load_data) &&
      first_timer_reload == {$past(upper_in), $past(acc_in)}) else $error("running load");
   chk_display_load: assert property (
      instr_valid && instr == `TIOD_OP_LOAD_DISP |=> display_timer_load &&
      display_timer_count == $past(acc_in) && display_timer_reload_latch == $past(acc_in))
      else $error("display load");
   chk_first_port: assert property (
      instr_valid && instr == `TIOD_OP_WRITE_PORT0 |=> first_bidir_port_out == $past(acc_in))
      else $error("first port");
   chk_second_port: assert property (
      instr_valid && instr == `TIOD_OP_WRITE_PORT1 |=> second_bidir_port_out == $past(acc_in))
      else $error("second port");
   chk_clear_bit: assert property (
      instr_valid && instr == `TIOD_OP_CLR_D && index_y < 10 |=>
      !output_port[$past(index_y)]) else $error("bit clear");
   chk_set_bit: assert property (
      instr_valid && instr == `TIOD_OP_SET_D && index_y < 10 |=>
      output_port[$past(index_y)]) else $error("bit set");
   chk_pullup_write: assert property (
      instr_valid && instr == `TIOD_OP_WRITE_PU |=> pullup_enable_register == $past(acc_in))
      else $error("pull-up write");
   chk_pullup_read: assert property (
      instr_valid && instr == `TIOD_OP_READ_PU |=> acc_we &&
      acc_out == $past(pullup_enable_register)) else $error("pull-up read");
   chk_set_all: assert property (
      instr_valid && instr == `TIOD_OP_SET_ALL_D |=> output_port == 10'h3ff)
      else $error("set all");
   chk_one_cycle: assert property (
      instr_done == $past(instr_valid)) else $error("done pulse");
endmodule // tiod_decoder_asserts
bind tiod_decoder tiod_decoder_asserts chk_u (.*);

/* File: verification/tiod_pins.sv */
// Purpose: port pins outside the decoder
// Assumes: pins change asynchronously to clk
// Notes: levels move 1 ns after an edge
module tiod_pins (
   // clock and requested levels
   input wire logic clk,
   input wire logic [11:0] lvl,
   // pin levels
   output logic [3:0] first_pins,
   output logic [3:0] second_pins,
   output logic [3:0] input_pins
);
   timeunit 1ns;
   timeprecision 1ps;
   // drive pins off the edge so the synchroniser sees a true async change
   always @(posedge clk) #1 {input_pins, second_pins, first_pins} <= lvl;
endmodule // tiod_pins

/* File: verification/tiod_decoder_tb.sv */
// Purpose: self-checking bench for the transfer decoder
// Assumes: ce held high
// Notes: acc results are matched against a queue of notes
`include "tiod_defines.vh"
module tiod_decoder_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_b = 0, instr_valid = 0, timer_run = 0, acc_we;
   logic [9:0] instr = 0, dm = 0, oport;
   logic [3:0] acc_in = 0, upper_in = 0, index_y = 0, pu_m = 0, pin_a, pin_b, pin_c;
   logic [3:0] acc_out, out_a, out_b, pu, awaddr = 0, araddr = 0;
   logic [7:0] t1_in = 0;
   logic [11:0] lvl = 0;
   logic [31:0] r = 32'hdcd76383, d, wdata = 0, rdata;
   logic [1:0] rs, bresp, rresp;
   logic [3:0] exp_q[$];
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid;
   int error_cnt = 0, check_count = 0, cyc = 0, n_ex = 0;
   always #2 clk = ~clk;
   tiod_pins pins_u (.clk(clk), .lvl(lvl), .first_pins(pin_a), .second_pins(pin_b),
      .input_pins(pin_c));
   tiod_decoder dut_u (.clk(clk), .rst_b(rst_b), .ce(1'b1), .instr(instr),
      .instr_valid(instr_valid), .acc_in(acc_in), .upper_in(upper_in), .index_y(index_y),
      .timer_run(timer_run), .first_timer_count_in(t1_in), .acc_out(acc_out),
      .acc_we(acc_we), .upper_out(), .upper_we(), .instr_done(), .first_timer_load_data(),
      .first_timer_load(), .first_timer_reload(), .display_timer_count(),
      .display_timer_load(), .display_timer_reload_latch(), .first_bidir_port_pin(pin_a),
      .second_bidir_port_pin(pin_b), .input_only_port_pin(pin_c), .first_bidir_port_out(out_a),
      .second_bidir_port_out(out_b), .output_port(oport), .pullup_enable_register(pu),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic chk(input logic [63:0] g, e);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // one word per edge; valid stays up so calls run back to back
   task automatic ex(input logic [9:0] op, input logic [3:0] y);
      @(posedge clk);
      r = lfsr(r);
      n_ex++;
      instr <= op;
      instr_valid <= 1;
      index_y <= y;
      timer_run <= y[0];
      acc_in <= r[3:0];
      upper_in <= r[7:4];
      t1_in <= r[15:8];
      case (op)
         `TIOD_OP_READ_T1: exp_q.push_back(r[11:8]);
         `TIOD_OP_READ_PORT0: exp_q.push_back(lvl[3:0]);
         `TIOD_OP_READ_PORT1: exp_q.push_back(lvl[7:4]);
         `TIOD_OP_READ_PORT2: exp_q.push_back(lvl[11:8]);
         `TIOD_OP_WRITE_PU: pu_m = r[3:0];
         `TIOD_OP_READ_PU: exp_q.push_back(pu_m);
         `TIOD_OP_SET_ALL_D: dm = 10'h3ff;
         `TIOD_OP_CLR_D: if (y < 10) dm[y] = 0;
         `TIOD_OP_SET_D: if (y < 10) dm[y] = 1;
         default: ;
      endcase
   endtask
   // axi4-lite write: address and data offered together, each dropped when taken
   task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rsp);
      @(posedge clk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end while (!bvalid);
      rsp = bresp;
      bready <= 0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rsp);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 0;
      end while (!rvalid);
      v = rdata;
      rsp = rresp;
      rready <= 0;
   endtask
   task results;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // match each accumulator write-back with the oldest note
   always @(posedge clk) if (rst_b && acc_we === 1'b1) begin
      if (exp_q.size() == 0) chk(1, 0);
      else chk(acc_out, exp_q.pop_front());
   end
   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         results();
      end
   end
   // main sequence
   initial begin
      repeat (10) @(posedge clk);
      rst_b <= 1;
      chk({out_a, out_b, pu, oport}, {8'hff, 4'h0, 10'h000});
      wr(`TIOD_REG_CTRL, 32'h1, rs);
      chk(rs, `TIOD_RESP_OKAY);
      rd(4'hc, d, rs);
      chk({rs, d}, {`TIOD_RESP_SLVERR, 32'h0});
      lvl <= r[27:16];
      repeat (8) @(posedge clk);
      ex(`TIOD_OP_READ_PORT0, 0);
      ex(`TIOD_OP_READ_PORT1, 0);
      ex(`TIOD_OP_READ_PORT2, 0);
      ex(`TIOD_OP_READ_T1, 0);
      ex(`TIOD_OP_LOAD_T1, 0);
      ex(`TIOD_OP_LOAD_T1, 1);
      ex(`TIOD_OP_LOAD_DISP, 0);
      ex(`TIOD_OP_WRITE_PORT0, 0);
      ex(`TIOD_OP_WRITE_PORT1, 0);
      ex(`TIOD_OP_WRITE_PU, 0);
      ex(`TIOD_OP_READ_PU, 0);
      ex(`TIOD_OP_SET_ALL_D, 0);
      for (int i = 0; i < 11; i++) ex(`TIOD_OP_CLR_D, i[3:0]);
      for (int i = 0; i < 11; i += 3) ex(`TIOD_OP_SET_D, i[3:0]);
      @(posedge clk);
      instr_valid <= 0;
      repeat (4) @(posedge clk);
      chk(oport, dm);
      rd(`TIOD_REG_STATUS, d, rs);
      chk({d[23:20], d[9:0]}, {pu_m, dm});
      chk(d[19:10], `TIOD_OP_SET_D);
      rd(`TIOD_REG_COUNT, d, rs);
      chk({rs, d}, {`TIOD_RESP_OKAY, 16'h0000, n_ex[15:0]});
      rd(`TIOD_REG_CTRL, d, rs);
      chk({rs, d}, {`TIOD_RESP_OKAY, 32'h1});
      chk(exp_q.size(), 0);
      results();
   end
endmodule // tiod_decoder_tb
